//--- ppt_pkg.sv
// shared constants, register map and types of the periodic pulse train generator
package ppt_pkg;
  // reference time base
  localparam int unsigned SYS_CLK_HZ   = 250_000_000;
  localparam int unsigned TEN_MEG_HZ   = 10_000_000;
  localparam int unsigned PRESCALE     = SYS_CLK_HZ / TEN_MEG_HZ;
  localparam logic [4:0]  PRESCALE_TOP = 5'(PRESCALE - 1);
  localparam int unsigned NUM_REFS     = 5;
  localparam logic [3:0]  DECADE_TOP   = 4'h9;
  // channel numbering over all chips
  localparam int unsigned NUM_CHIPS      = 6;
  localparam int unsigned CHANS_PER_CHIP = 3;
  localparam int unsigned NUM_CHANS      = NUM_CHIPS * CHANS_PER_CHIP;
  localparam int unsigned CHIP_STRIDE    = 4;
  localparam int unsigned STAGE_OFFSET   = 2;
  localparam int unsigned IDX_W          = 5;
  localparam logic [IDX_W-1:0] NUM_CHANS_C   = IDX_W'(NUM_CHANS);
  localparam logic [IDX_W-1:0] ONESHOT_BACK  = IDX_W'(STAGE_OFFSET);
  localparam logic [IDX_W-1:0] RATE_BACK     = IDX_W'(2 * STAGE_OFFSET);
  localparam logic [IDX_W-1:0] NEIGHBOR_BACK = IDX_W'(3 * STAGE_OFFSET);
  localparam int unsigned CNT_W          = 16;
  // register map
  localparam int unsigned REG_AW     = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SELECT   = 8'h04;
  localparam logic [7:0] ADDR_CLOCKS   = 8'h08;
  localparam logic [7:0] ADDR_PULSE    = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD   = 8'h10;
  localparam logic [7:0] ADDR_DURATION = 8'h14;
  localparam logic [7:0] ADDR_RATE     = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  // field positions
  localparam int unsigned SEL_CHAN_LSB  = 8;
  localparam int unsigned CLK_DUR_LSB   = 4;
  localparam int unsigned CLK_RATE_LSB  = 8;
  localparam int unsigned FORM_BIT      = 16;
  localparam int unsigned GATE_LSB      = 16;
  localparam int unsigned ST_DUR_LSB    = 8;
  localparam int unsigned ST_RATE_LSB   = 16;
  localparam int unsigned ST_OUT_LSB    = 24;
  localparam int unsigned ST_ERR_BIT    = 27;
  localparam int unsigned ST_STATE_LSB  = 28;
  // clock source codes
  localparam logic [2:0] clk_sel_ten_meg   = 3'h1;
  localparam logic [2:0] clk_sel_one_meg   = 3'h2;
  localparam logic [2:0] clk_sel_hundred_k = 3'h3;
  localparam logic [2:0] clk_sel_ten_k     = 3'h4;
  localparam logic [2:0] clk_sel_one_k     = 3'h5;
  // rate gate source codes
  localparam logic [1:0] gate_tied_high     = 2'h0;
  localparam logic [1:0] gate_tied_low      = 2'h1;
  localparam logic [1:0] gate_external_pin  = 2'h2;
  localparam logic [1:0] gate_inverted_neighbor = 2'h3;
  // pulse forms
  localparam logic FORM_STROBE = 1'b0;
  localparam logic FORM_SQUARE = 1'b1;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic             run;
    logic [4:0]       output_chip_select;
    logic [1:0]       output_channel_select;
    logic [2:0]       output_clock_select;
    logic [2:0]       duration_clock_select;
    logic [2:0]       rate_clock_select;
    logic [CNT_W-1:0] pulses_per_train;
    logic             pulse_form_select;
    logic [CNT_W-1:0] pulse_period;
    logic [CNT_W-1:0] train_duration;
    logic [CNT_W-1:0] repetition_rate;
    logic [1:0]       rate_gate_select;
  } ppt_cfg_t;

  localparam ppt_cfg_t CFG_RESET = '{run: 1'b0, output_chip_select: 5'h00,
    output_channel_select: 2'h0, output_clock_select: 3'h1, duration_clock_select: 3'h1,
    rate_clock_select: 3'h1, pulses_per_train: 16'h0001, pulse_form_select: 1'b0,
    pulse_period: 16'h0002, train_duration: 16'h0001, repetition_rate: 16'h0002,
    rate_gate_select: 2'h0};

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_RUN  = 2'b01,
    PS_DONE = 2'b11
  } ppt_pstate_t;
endpackage

//--- ppt_pulse_train.sv
// periodic pulse train generator: three timer channels behind an axi4-lite slave
// Functional notes
// - the pulse channel emits exactly the configured pulse count in every train; the code emits fewer if the one-shot ends before the last pulse
// - the duration channel is a retriggerable one-shot that sets train length
// - the rate channel is periodic and retriggers the one-shot once per period
// - one-shot sits two channels below pulse, rate two below one-shot
// - offsets use one index over all channels of all chips
// - an offset below the lowest chip wraps to the highest chip
// - inverted one-shot output gates the pulse channel
// - rate channel output gates the one-shot, not inverted
// - each channel picks 10 MHz, 1 MHz, 100 kHz, 10 kHz or 1 kHz by code 1..5
// - form 0 gives one-clock low pulses, form 1 low-going square pulses
// - rate gate: 0 high, 1 low, 2 external pin, 3 inverted neighbour output
// - train rate is the rate clock divided by an integer
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
module ppt_pulse_train
  import ppt_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // axi4-lite write address and data
  input  wire logic [REG_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [REG_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // gate pins
  input  wire logic                 gate_ext_pin,
  input  wire logic [NUM_CHANS-1:0] neighbor_out,
  // timer outputs
  output logic                      pulse_out,
  output logic                      duration_out,
  output logic                      rate_out,
  output logic [NUM_CHANS-1:0]      chan_out
);

  ppt_cfg_t             cfg_q;
  ppt_pstate_t          pstate_q;
  logic [4:0]           pre_cnt_q;
  logic [NUM_REFS-1:0]  tick;
  logic [CNT_W-1:0]     rate_cnt_q;
  logic [CNT_W-1:0]     dur_cnt_q;
  logic [CNT_W-1:0]     phase_q;
  logic [CNT_W-1:0]     emitted_q;
  logic                 rate_out_q;
  logic                 rate_prev_q;
  logic                 dur_out_q;
  logic                 pgate_prev_q;
  logic                 pulse_out_q;
  logic [NUM_CHANS-1:0] chan_out_q;
  logic                 aw_have_q;
  logic                 w_have_q;
  logic [REG_AW-1:0]    aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;

  // ---- channel index resolution
  function automatic logic [IDX_W-1:0] idx_back(input logic [IDX_W-1:0] i,
                                                input logic [IDX_W-1:0] k);
    if (i >= k) begin
      return i - k;
    end
    return i + NUM_CHANS_C - k;
  endfunction

  logic [2:0]       chip_num;
  logic             sel_err;
  logic [IDX_W-1:0] pulse_idx;
  logic [IDX_W-1:0] dur_idx;
  logic [IDX_W-1:0] rate_idx;
  logic [IDX_W-1:0] nbr_idx;
  logic             active;

  assign chip_num  = 3'(cfg_q.output_chip_select / CHIP_STRIDE);
  // bad selections stop the generator rather than driving some odd channel
  assign sel_err   = (5'(cfg_q.output_chip_select % CHIP_STRIDE) != 5'h00)
                   || (32'(chip_num) >= NUM_CHIPS)
                   || (32'(cfg_q.output_channel_select) >= CHANS_PER_CHIP);
  assign pulse_idx = IDX_W'(32'(chip_num) * CHANS_PER_CHIP
                   + 32'(cfg_q.output_channel_select));
  assign dur_idx   = idx_back(pulse_idx, ONESHOT_BACK);
  assign rate_idx  = idx_back(pulse_idx, RATE_BACK);
  assign nbr_idx   = idx_back(pulse_idx, NEIGHBOR_BACK);
  assign active    = cfg_q.run && !sel_err;

  // ---- reference clock enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_q <= 5'h00;
    end else if (ce) begin
      pre_cnt_q <= (pre_cnt_q == PRESCALE_TOP) ? 5'h00 : pre_cnt_q + 5'h01;
    end
  end

  assign tick[0] = ce && (pre_cnt_q == PRESCALE_TOP);

  genvar g;
  generate
    for (g = 1; g < NUM_REFS; g++) begin : g_decade
      logic [3:0] dec_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dec_q <= 4'h0;
        end else if (tick[g-1]) begin
          dec_q <= (dec_q == DECADE_TOP) ? 4'h0 : dec_q + 4'h1;
        end
      end
      assign tick[g] = tick[g-1] && (dec_q == DECADE_TOP);
    end
  endgenerate

  // unknown codes (incl. -1) give no ticks: automatic choice is the host's job
  function automatic logic ref_tick(input logic [2:0] code, input logic [NUM_REFS-1:0] t);
    case (code)
      clk_sel_ten_meg:   return t[0];
      clk_sel_one_meg:   return t[1];
      clk_sel_hundred_k: return t[2];
      clk_sel_ten_k:     return t[3];
      clk_sel_one_k:     return t[4];
      default:           return 1'b0;
    endcase
  endfunction

  logic out_tick;
  logic dur_tick;
  logic rate_tick;
  logic rate_gate;

  assign out_tick  = ref_tick(cfg_q.output_clock_select, tick);
  assign dur_tick  = ref_tick(cfg_q.duration_clock_select, tick);
  assign rate_tick = ref_tick(cfg_q.rate_clock_select, tick);

  always_comb begin
    case (cfg_q.rate_gate_select)
      gate_tied_high:         rate_gate = 1'b1;
      gate_tied_low:          rate_gate = 1'b0;
      gate_external_pin:      rate_gate = gate_ext_pin;
      gate_inverted_neighbor: rate_gate = !neighbor_out[nbr_idx];
      default:                rate_gate = 1'b0;
    endcase
  end

  // ---- rate channel: low for one rate tick every repetition_rate ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_q <= CFG_RESET.repetition_rate;
      rate_out_q <= 1'b1;
    end else if (ce) begin
      if (!active) begin
        rate_cnt_q <= cfg_q.repetition_rate;
        rate_out_q <= 1'b1;
      end else if (!rate_gate) begin
        rate_out_q <= 1'b1;
      end else if (rate_tick) begin
        if (rate_cnt_q <= 16'h0001) begin
          rate_cnt_q <= cfg_q.repetition_rate;
          rate_out_q <= 1'b0;
        end else begin
          rate_cnt_q <= rate_cnt_q - 16'h0001;
          rate_out_q <= 1'b1;
        end
      end
    end
  end

  // ---- one-shot: gate is the rate output, low while active
  logic dur_trig;
  assign dur_trig = rate_out_q && !rate_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_prev_q <= 1'b1;
      dur_cnt_q   <= CFG_RESET.train_duration;
      dur_out_q   <= 1'b1;
    end else if (ce) begin
      rate_prev_q <= rate_out_q;
      if (!active) begin
        dur_out_q <= 1'b1;
      end else if (dur_trig) begin
        dur_cnt_q <= cfg_q.train_duration;
        dur_out_q <= 1'b0;
      end else if (!dur_out_q && rate_out_q && dur_tick) begin
        if (dur_cnt_q <= 16'h0001) begin
          dur_out_q <= 1'b1;
        end else begin
          dur_cnt_q <= dur_cnt_q - 16'h0001;
        end
      end
    end
  end

  // ---- pulse channel
  logic             pulse_gate;
  logic             pulse_rise;
  logic [CNT_W-1:0] eff_period;
  logic [CNT_W-1:0] last_phase;
  logic             low_phase;

  assign pulse_gate = active && !dur_out_q;
  assign pulse_rise = pulse_gate && !pgate_prev_q;
  // a period below two would merge pulses into a steady low
  assign eff_period = (cfg_q.pulse_period < 16'h0002) ? 16'h0002 : cfg_q.pulse_period;
  assign last_phase = eff_period - 16'h0001;
  assign low_phase  = (cfg_q.pulse_form_select == FORM_STROBE)
                    ? (phase_q == last_phase)
                    : (phase_q >= (eff_period >> 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgate_prev_q <= 1'b0;
      pstate_q     <= PS_IDLE;
      phase_q      <= '0;
      emitted_q    <= '0;
    end else if (ce) begin
      pgate_prev_q <= pulse_gate;
      if (!active) begin
        pstate_q <= PS_IDLE;
      end else if (pulse_rise) begin
        phase_q   <= '0;
        emitted_q <= '0;
        pstate_q  <= (cfg_q.pulses_per_train == '0) ? PS_DONE : PS_RUN;
      end else begin
        case (pstate_q)
          PS_RUN: begin
            if (pulse_gate && out_tick) begin
              if (phase_q == last_phase) begin
                phase_q   <= '0;
                emitted_q <= emitted_q + 16'h0001;
                if (emitted_q + 16'h0001 == cfg_q.pulses_per_train) begin
                  pstate_q <= PS_DONE;
                end
              end else begin
                phase_q <= phase_q + 16'h0001;
              end
            end
          end
          PS_IDLE: pstate_q <= PS_IDLE;
          PS_DONE: pstate_q <= PS_DONE;
          default: pstate_q <= PS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out_q <= 1'b1;
    end else if (ce) begin
      pulse_out_q <= !(pstate_q == PS_RUN && pulse_gate && low_phase);
    end
  end

  // ---- channel pins at their resolved positions; unused channels idle high
  generate
    for (g = 0; g < NUM_CHANS; g++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chan_out_q[g] <= 1'b1;
        end else if (ce) begin
          if (!active) begin
            chan_out_q[g] <= 1'b1;
          end else if (pulse_idx == IDX_W'(g)) begin
            chan_out_q[g] <= pulse_out_q;
          end else if (dur_idx == IDX_W'(g)) begin
            chan_out_q[g] <= dur_out_q;
          end else if (rate_idx == IDX_W'(g)) begin
            chan_out_q[g] <= rate_out_q;
          end else begin
            chan_out_q[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  assign pulse_out    = pulse_out_q;
  assign duration_out = dur_out_q;
  assign rate_out     = rate_out_q;
  assign chan_out     = chan_out_q;

  // ---- register image
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[IDX_W-1:0] = pulse_idx;
    status_word[ST_DUR_LSB +: IDX_W] = dur_idx;
    status_word[ST_RATE_LSB +: IDX_W] = rate_idx;
    status_word[ST_OUT_LSB +: 3] = {rate_out_q, dur_out_q, pulse_out_q};
    status_word[ST_ERR_BIT] = sel_err;
    status_word[ST_STATE_LSB +: 2] = pstate_q;
  end

  function automatic logic [31:0] reg_image(input logic [REG_AW-1:0] a, input ppt_cfg_t c,
                                            input logic [31:0] st);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_CTRL:     v[0] = c.run;
      ADDR_SELECT: begin
        v[4:0] = c.output_chip_select;
        v[SEL_CHAN_LSB +: 2] = c.output_channel_select;
      end
      ADDR_CLOCKS: begin
        v[2:0] = c.output_clock_select;
        v[CLK_DUR_LSB +: 3] = c.duration_clock_select;
        v[CLK_RATE_LSB +: 3] = c.rate_clock_select;
      end
      ADDR_PULSE: begin
        v[CNT_W-1:0] = c.pulses_per_train;
        v[FORM_BIT] = c.pulse_form_select;
      end
      ADDR_PERIOD:   v[CNT_W-1:0] = c.pulse_period;
      ADDR_DURATION: v[CNT_W-1:0] = c.train_duration;
      ADDR_RATE: begin
        v[CNT_W-1:0] = c.repetition_rate;
        v[GATE_LSB +: 2] = c.rate_gate_select;
      end
      ADDR_STATUS:   v = st;
      default:       v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [REG_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_STATUS);
  endfunction

  // ---- axi4-lite write path: address and data taken in either order
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] wmerged;

  // readies drop with ce so no handshake is lost while frozen
  assign s_axi_awready = ce && !aw_have_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_have_q && !bvalid_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
  end
  assign wmerged = (reg_image(aw_addr_q, cfg_q, status_word) & ~wmask) | (w_data_q & wmask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration takes effect at once; counters pick it up on next reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (ce && wr_fire) begin
      case (aw_addr_q)
        ADDR_CTRL:     cfg_q.run <= wmerged[0];
        ADDR_SELECT: begin
          cfg_q.output_chip_select    <= wmerged[4:0];
          cfg_q.output_channel_select <= wmerged[SEL_CHAN_LSB +: 2];
        end
        ADDR_CLOCKS: begin
          cfg_q.output_clock_select   <= wmerged[2:0];
          cfg_q.duration_clock_select <= wmerged[CLK_DUR_LSB +: 3];
          cfg_q.rate_clock_select     <= wmerged[CLK_RATE_LSB +: 3];
        end
        ADDR_PULSE: begin
          cfg_q.pulses_per_train  <= wmerged[CNT_W-1:0];
          cfg_q.pulse_form_select <= wmerged[FORM_BIT];
        end
        ADDR_PERIOD:   cfg_q.pulse_period <= wmerged[CNT_W-1:0];
        ADDR_DURATION: cfg_q.train_duration <= wmerged[CNT_W-1:0];
        ADDR_RATE: begin
          cfg_q.repetition_rate  <= wmerged[CNT_W-1:0];
          cfg_q.rate_gate_select <= wmerged[GATE_LSB +: 2];
        end
        default:       cfg_q <= cfg_q;
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ---- axi4-lite read path
  assign s_axi_arready = ce && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= reg_image(s_axi_araddr, cfg_q, status_word);
        rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

//--- ppt_monitor.sv
// bus handshake and timer output checks for the pulse train generator
module ppt_monitor
  import ppt_pkg::*;
(
  // clock, reset and enable
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 ce,
  // bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  // timers
  input wire logic                 pulse_out,
  input wire logic                 duration_out,
  input wire logic                 rate_out,
  input wire logic [NUM_CHANS-1:0] chan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_ar_block; s_axi_arready == (ce && !s_axi_rvalid); endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready wrong");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during answer");
  // the later of address and data is taken two edges before the answer rises
  property p_b_cause;
    $rose(s_axi_bvalid)
      |-> $past((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready), 2);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("write answer without cause");
  property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_r_cause: assert property (p_r_cause) else $error("read answer without cause");
  property p_idle; $rose(aresetn) |-> pulse_out && duration_out && rate_out && &chan_out; endproperty
  a_idle: assert property (p_idle) else $error("outputs not idle after reset");
  // pipeline slack of up to three cycles between gate and output
  property p_gate; $fell(pulse_out) |-> !$past(duration_out) || !$past(duration_out, 2) || !$past(duration_out, 3); endproperty
  a_gate: assert property (p_gate) else $error("pulse outside train");
  property p_trig; $fell(duration_out) |-> $past(rate_out) && !$past(rate_out, 4); endproperty
  a_trig: assert property (p_trig) else $error("one-shot start not from rate rise");
endmodule
bind ppt_pulse_train ppt_monitor u_mon (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pulse_out, .duration_out,
  .rate_out, .chan_out);

//--- ppt_board_model.sv
// board side stand-in: external gate pin and neighbour outputs
module ppt_board_model
  import ppt_pkg::*;
(
  // levels set by the bench
  input wire logic                 ext_level,
  input wire logic                 nb_level,
  // pins toward the generator
  output logic                     gate_ext_pin,
  output logic [NUM_CHANS-1:0]     neighbor_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign gate_ext_pin = ext_level;
  assign neighbor_out = {NUM_CHANS{nb_level}};
endmodule

//--- ppt_pulse_train_tb.sv
// self-checking bench of the pulse train generator
module ppt_pulse_train_tb
  import ppt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ext = 1, nb = 1;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, d, seed = 32'h44180f7d;
  logic [1:0] bresp, rresp, r;
  logic awr, wr_r, bv, arr, rv, gep, po, dout, ro;
  logic [NUM_CHANS-1:0] nbo, co;
  int err_count = 0, samples_checked = 0, cyc = 0, n, lw, np, per, t, f;
  logic [31:0] rst_tab [7] = '{32'h0, 32'h0, 32'h111, 32'h1, 32'h2, 32'h1, 32'h2};
  logic [4:0] gt [6] = '{5'h07, 5'h0e, 5'h12, 5'h17, 5'h1e, 5'h1d};
  always #2 aclk = ~aclk;
  ppt_board_model bm (.ext_level(ext), .nb_level(nb), .gate_ext_pin(gep), .neighbor_out(nbo));
  ppt_pulse_train uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .gate_ext_pin(gep),
    .neighbor_out(nbo), .pulse_out(po), .duration_out(dout), .rate_out(ro), .chan_out(co));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_st(input int p);
    return {11'h0, 5'((p + 14) % 18), 3'h0, 5'((p + 16) % 18), 3'h0, 5'(p)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rd_d;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("chan_out", 32'(co), 32'h3ffff);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk("reset value", d, rst_tab[i]);
    end
    rd(8'h20);
    chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    chk("unmapped data", d, 32'h0);
    wr(8'h22, 32'h1);
    chk("unaligned write", 32'(r), 32'(RESP_SLVERR));
    wr(ADDR_STATUS, 32'hffffffff);
    chk("status write", 32'(r), 32'(RESP_OKAY));
    for (int p = 0; p < 18; p++) begin
      wr(ADDR_SELECT, 32'((p % 3) << 8 | (p / 3) * 4));
      rd(ADDR_STATUS);
      chk("stage index", d & 32'h001f1f1f, exp_st(p));
    end
    wr(ADDR_SELECT, 32'h300);
    rd(ADDR_STATUS);
    chk("bad select", 32'(d[27]), 32'h1);
    wr(ADDR_CLOCKS, 32'h111);
    wr(ADDR_PERIOD, 32'h4);
    wr(ADDR_DURATION, 32'd30);
    for (int k = 0; k < 4; k++) begin
      n = 1 + rnd() % 5;
      f = rnd() % 2;
      wr(ADDR_CTRL, 32'h0);
      lw = int'((rnd() % 3) << 8 | (rnd() % 6) * 4);
      wr(ADDR_SELECT, 32'(lw));
      wr(ADDR_PULSE, 32'(f << 16 | n));
      rd(ADDR_PULSE);
      chk("pulse reg", d, 32'(f << 16 | n));
      wr(ADDR_RATE, 32'd60);
      wr(ADDR_CTRL, 32'h1);
      @(negedge ro);
      t = cyc;
      @(negedge ro);
      per = cyc - t;
      chk("rate period", 32'(per), 32'd1500);
      @(negedge dout);
      np = ((lw & 31) / 4 * 3 + (lw >> 8) + 16) % 18;
      repeat (2) @(posedge aclk);
      chk("one-shot pin", 32'(co[np]), 32'h0);
      np = 0;
      lw = 0;
      while (dout === 1'b0) begin
        @(posedge aclk);
        if (po === 1'b0) lw++;
        if (po === 1'b0 && t == 1) np++;
        t = (po === 1'b0) ? 0 : 1;
      end
      chk("pulse count", 32'(np), 32'(n));
      chk("low time", 32'(lw), 32'(n * (f ? 50 : 25)));
    end
    for (int g = 0; g < 6; g++) begin
      wr(ADDR_CTRL, 32'h0);
      ext <= gt[g][2];
      nb <= gt[g][1];
      wr(ADDR_RATE, 32'(gt[g][4:3]) << 16 | 32'd60);
      wr(ADDR_CTRL, 32'h1);
      f = 0;
      repeat (3100) begin
        @(posedge aclk);
        if (ro === 1'b0 && t == 1) f++;
        t = (ro === 1'b0) ? 0 : 1;
      end
      chk("rate gate", 32'(f > 0), 32'(gt[g][0]));
    end
    end_sim();
  end
endmodule
